// [fcv_config_one.v]
// Functional notes
// - Read-config returns register; read-any, write-any, write-status access it.
// - Bits 5,3,2 mirror the nonvolatile protection and layout bits.
// - Host writes to bits 5,3,2 are ignored.
// - Bit 1 set selects 4-bit path; protect pin becomes data, reset pin only while chip select is low.
// - In 4-bit width the write-protect function is held inactive high.
// - Single and dual reads still work in 4-bit width.
// - Width bit cannot be cleared while four-bit instruction mode is set.
// - Write-status command programs nonvolatile width and volatile width in the same cycle.
// - Write-any to volatile width leaves nonvolatile default unchanged.
// - Lock bit freezes protect bits, OTP layout bits and OTP area.
// - Locked writes leave frozen bits unchanged, no error flag.
// - Locked OTP program inside OTP area fails and flags program error.
// - Unlocked, protection bits, lock and OTP area are writable.
// - Lock clears only on power cycle or hardware reset.
// - At power-on lock loads from nonvolatile lock default bit 0.
// - One write may set lock and update other bits together.
// - Lock never blocks width bits; it blocks the whole status byte, status-write-disable included.
// - Reset loads volatile width from nonvolatile width default bit 1.
//
// Serial command decoder for volatile configuration register one.
// Assumes the serial clock arrives as a plain pin sampled by i_clk, which
// must run at least four times faster; the nonvolatile store is outside.
`timescale 1ns/1ps
`include "fcv_consts.vh"
module fcv_config_one #(
   parameter ADDR_W = 24 // Address width of register commands.
) (
   input  wire       i_clk,          // Block clock, 20 MHz.
   input  wire       i_sys_rst,      // Power-on reset, active high.
   input  wire       i_ce,           // Clock enable.
   input  wire       i_hw_rst_n,     // Hardware reset strobe, active low.
   input  wire       i_sw_rst,       // Software reset pulse, same domain.
   input  wire       i_sck,          // Serial clock pin.
   input  wire       i_cs_n,         // Chip select pin, active low.
   input  wire       i_si,           // Serial data in pin.
   input  wire       i_wp_n_in,      // Write-protect / data 2 pin input.
   input  wire       i_rst_io3_in,   // Reset / data 3 pin input.
   input  wire [7:0] i_nv_cfg,       // Nonvolatile config register one.
   input  wire       i_qpi,          // Four-bit instruction mode bit.
   input  wire       i_otp_busy,     // Nonvolatile write in progress.
   output reg        o_so,           // Serial data out.
   output reg        o_so_oe_n,      // Output enable of data out, low on.
   output reg        o_wide,         // Four-bit data width selected.
   output reg        o_lock,         // Protection lock bit.
   output wire       o_wp_n,         // Effective write-protect, low active.
   output wire       o_io3_rst_n,    // Reset seen on data 3 pin.
   output wire       o_io2_data,     // Data 2 value in wide mode.
   output wire       o_io3_data,     // Data 3 value in wide mode.
   output reg        o_nv_wr,        // Pulse: write nonvolatile register.
   output reg  [7:0] o_nv_wdata,     // Data for nonvolatile write.
   output reg        o_bp_wr,        // Pulse: write protect bits allowed.
   output reg  [7:0] o_bp_wdata,     // Status byte for protect write.
   output reg        o_otp_wr,       // Pulse: program OTP location.
   output reg        o_prog_err      // Program error flag, sticky.
);
   // ==========================================================
   // Pin synchronisers
   wire sck_s;
   wire cs_n_s;
   wire si_s;
   wire wp_s;
   wire io3_s;
   wire hwr_s;
   wire [5:0] pins_in = {i_sck, i_cs_n, i_si, i_wp_n_in, i_rst_io3_in,
                         i_hw_rst_n};
   wire [5:0] pins_s;
   // Idle levels: clock low, select high, data low, protect, io3, reset high.
   localparam [5:0] PIN_IDLE = 6'h17;
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_sync
         fcv_sync u_sync (
            .i_clk     (i_clk),
            .i_sys_rst (i_sys_rst),
            .i_ce      (i_ce),
            .i_rst_val (PIN_IDLE[g]),
            .i_async   (pins_in[g]),
            .o_sync    (pins_s[g])
         );
      end
   endgenerate
   assign {sck_s, cs_n_s, si_s, wp_s, io3_s, hwr_s} = pins_s;

   // ==========================================================
   // Serial clock edge detection
   reg  sck_d;
   reg  cs_d;
   wire sck_rise = sck_s & ~sck_d;
   wire sck_fall = ~sck_s & sck_d;
   wire cs_end   = cs_n_s & ~cs_d;
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         sck_d <= 1'b0;
         cs_d  <= 1'b1;
      end else if (i_ce) begin
         sck_d <= sck_s;
         cs_d  <= cs_n_s;
      end
   end

   // ==========================================================
   // Pin functions in wide mode
   assign o_wp_n      = o_wide ? 1'b1 : wp_s;
   assign o_io2_data  = o_wide ? wp_s : 1'b0;
   assign o_io3_data  = (o_wide & ~cs_n_s) ? io3_s : 1'b0;
   assign o_io3_rst_n = (o_wide & ~cs_n_s) ? 1'b1 : io3_s;

   // ==========================================================
   // Register view
   wire [7:0] reg_view = {2'b00, i_nv_cfg[`FCV_BIT_ORIGIN], 1'b0,
                          i_nv_cfg[`FCV_BIT_VOLATILITY],
                          i_nv_cfg[`FCV_BIT_PARAM_PLACE],
                          o_wide, o_lock};

   // Merges a written byte: shadows and reserved bits stay, lock only sets.
   function [7:0] fcv_merge;
      input [7:0] cur;
      input [7:0] wr;
      input       four_bit_instruction_mode;
      reg         w;
      begin
         w = wr[`FCV_BIT_WIDE] | four_bit_instruction_mode;
         fcv_merge = {cur[7:2], w, cur[0] | wr[`FCV_BIT_LOCK]};
      end
   endfunction

   // Builds the nonvolatile byte: only the width default may change.
   function [7:0] fcv_nv_byte;
      input [7:0] nv;
      input [7:0] wr;
      input       four_bit_instruction_mode;
      begin
         fcv_nv_byte = {nv[7:2], wr[`FCV_BIT_WIDE] | four_bit_instruction_mode, nv[0]};
      end
   endfunction

   // ==========================================================
   // Command state machine
   localparam ST_CMD  = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_DATA = 3'h2;
   localparam ST_RD   = 3'h3;
   localparam ST_IGN  = 3'h4;

   reg [2:0]  state;
   reg [7:0]  cmd;
   reg [7:0]  shift;
   reg [4:0]  cnt;
   reg [ADDR_W-1:0] addr;
   reg [7:0]  status_b;
   reg [7:0]  out_sr;
   reg        got_status;
   reg        got_cfg;
   reg        hw_done;

   wire [7:0] shift_n = {shift[6:0], si_s};
   wire       byte_done = sck_rise & (cnt[2:0] == 3'h7);
   wire       in_otp    = (addr <= `FCV_OTP_TOP);
   wire       nv_target = (addr == `FCV_ADDR_CFG_ONE_NV);
   wire       v_target  = (addr == `FCV_ADDR_CFG_ONE_V);
   wire [7:0] merged    = fcv_merge(reg_view, shift_n, i_qpi);

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         state      <= ST_CMD;
         cmd        <= `FCV_RESET_VALUE;
         shift      <= `FCV_RESET_VALUE;
         cnt        <= 5'h00;
         addr       <= {ADDR_W{1'b0}};
         status_b   <= `FCV_RESET_VALUE;
         out_sr     <= `FCV_RESET_VALUE;
         got_status <= 1'b0;
         got_cfg    <= 1'b0;
         hw_done    <= 1'b0;
         o_so       <= 1'b0;
         o_so_oe_n  <= 1'b1;
         o_wide     <= 1'b0;
         o_lock     <= 1'b0;
         o_nv_wr    <= 1'b0;
         o_nv_wdata <= `FCV_RESET_VALUE;
         o_bp_wr    <= 1'b0;
         o_bp_wdata <= `FCV_RESET_VALUE;
         o_otp_wr   <= 1'b0;
         o_prog_err <= 1'b0;
      end else if (i_ce) begin
         o_nv_wr  <= 1'b0;
         o_bp_wr  <= 1'b0;
         o_otp_wr <= 1'b0;
         // Defaults load once after power-on and on each hardware reset.
         if (!hw_done || !hwr_s) begin
            o_wide  <= i_nv_cfg[`FCV_BIT_WIDE];
            o_lock  <= i_nv_cfg[`FCV_BIT_LOCK];
            hw_done <= 1'b1;
         end
         if (i_sw_rst)
            o_prog_err <= 1'b0;
         if (cs_n_s) begin
            state     <= ST_CMD;
            cnt       <= 5'h00;
            o_so_oe_n <= 1'b1;
            if (cs_end && got_status && cmd == `FCV_CMD_WRITE_STATUS_CONFIG)
               begin
               // Status-only write: lock blocks the whole byte, disable bit included.
               o_bp_wr    <= ~o_lock;
               o_bp_wdata <= status_b;
            end
            got_status <= 1'b0;
            got_cfg    <= 1'b0;
         end else if (sck_rise) begin
            shift <= shift_n;
            cnt   <= cnt + 5'h01;
            case (state)
               ST_CMD: begin
                  if (byte_done) begin
                     cmd <= shift_n;
                     cnt <= 5'h00;
                     case (shift_n)
                        `FCV_CMD_WRITE_STATUS_CONFIG: state <= ST_DATA;
                        `FCV_CMD_READ_CONFIG_ONE: begin
                           state  <= ST_RD;
                           out_sr <= reg_view;
                        end
                        `FCV_CMD_READ_ANY_REG,
                        `FCV_CMD_WRITE_ANY_REG,
                        `FCV_CMD_OTP_PROGRAM: state <= ST_ADDR;
                        default: state <= ST_IGN;
                     endcase
                  end
               end
               ST_ADDR: begin
                  addr <= {addr[ADDR_W-2:0], si_s};
                  if (cnt == 5'd23) begin
                     cnt <= 5'h00;
                     if (cmd == `FCV_CMD_READ_ANY_REG) begin
                        state  <= ST_RD;
                        out_sr <= reg_view;
                     end else
                        state <= ST_DATA;
                  end
               end
               ST_DATA: begin
                  if (byte_done) begin
                     case (cmd)
                        `FCV_CMD_WRITE_STATUS_CONFIG: begin
                           if (!got_status) begin
                              status_b   <= shift_n;
                              got_status <= 1'b1;
                           end else if (!got_cfg) begin
                              got_cfg    <= 1'b1;
                              got_status <= 1'b0;
                              o_bp_wr    <= ~o_lock;
                              o_bp_wdata <= status_b;
                              o_nv_wr    <= 1'b1;
                              o_nv_wdata <= fcv_nv_byte(i_nv_cfg, shift_n,
                                 i_qpi);
                              {o_wide, o_lock} <= merged[1:0];
                              state <= ST_IGN;
                           end
                        end
                        `FCV_CMD_WRITE_ANY_REG: begin
                           if (v_target)
                              {o_wide, o_lock} <= merged[1:0];
                           if (nv_target) begin
                              o_nv_wr    <= 1'b1;
                              o_nv_wdata <= fcv_nv_byte(i_nv_cfg, shift_n,
                                 i_qpi);
                           end
                           state <= ST_IGN;
                        end
                        `FCV_CMD_OTP_PROGRAM: begin
                           if (o_lock && in_otp)
                              o_prog_err <= 1'b1;
                           else if (in_otp && !i_otp_busy)
                              o_otp_wr <= 1'b1;
                           state <= ST_IGN;
                        end
                        default: state <= ST_IGN;
                     endcase
                  end
               end
               default: ;
            endcase
         end else if (sck_fall && state == ST_RD) begin
            o_so_oe_n <= 1'b0;
            o_so      <= out_sr[7];
            out_sr    <= {out_sr[6:0], out_sr[7]};
         end
      end
   end
endmodule // fcv_config_one

// [fcv_config_one_bench.sv]
// Self-checking bench for the volatile configuration register one block.
// Assumes fcv_host drives the serial pins and the checker is bound.
`timescale 1ns/1ps
`include "fcv_consts.vh"
module fcv_config_one_bench;
   reg        clk = 0, rst = 1, hw_n = 1, sw = 0, wp = 1, io3 = 1, four_bit_instruction_mode = 0;
   reg  [7:0] nv = 8'hFE;
   reg  [7:0] rd;
   wire       sck, cs_n, si, so, wide, lock, wp_n, err, nvw, bpw, otpw;
   wire [7:0] nvd, bpd;
   wire       oe_n, io3r, io2d, io3d;
   reg        ce = 1;
   integer    fail_count = 0, samples_checked = 0, n_nv = 0, n_bp = 0;
   integer    n_otp = 0;
   initial forever #25 clk = ~clk;
   fcv_host host (.i_clk(clk), .i_so(so), .o_sck(sck), .o_cs_n(cs_n),
      .o_si(si));
   fcv_config_one DUT (
      .i_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_hw_rst_n(hw_n),
      .i_sw_rst(sw), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
      .i_wp_n_in(wp), .i_rst_io3_in(io3), .i_nv_cfg(nv), .i_qpi(four_bit_instruction_mode),
      .i_otp_busy(1'b0), .o_so(so), .o_so_oe_n(oe_n), .o_wide(wide),
      .o_lock(lock), .o_wp_n(wp_n), .o_io3_rst_n(io3r), .o_io2_data(io2d),
      .o_io3_data(io3d), .o_nv_wr(nvw), .o_nv_wdata(nvd), .o_bp_wr(bpw),
      .o_bp_wdata(bpd), .o_otp_wr(otpw), .o_prog_err(err));
   always @(posedge clk) if (nvw === 1'b1) n_nv++;
   always @(posedge clk) if (bpw === 1'b1) n_bp++;
   always @(posedge clk) if (otpw === 1'b1) n_otp++;
   task automatic chk(input [7:0] seen, input [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input [7:0] d);
      host.xfer(`FCV_CMD_WRITE_ANY_REG, 1, `FCV_ADDR_CFG_ONE_V, {8'h00, d},
         1, rd);
   endtask
   task automatic write_status_config_cmd(input [15:0] d);
      host.xfer(`FCV_CMD_WRITE_STATUS_CONFIG, 0, 24'h000000, d, 2, rd);
   endtask
   task automatic otp;
      host.xfer(`FCV_CMD_OTP_PROGRAM, 1, 24'h000010, 16'h00A5, 1, rd);
   endtask
   task automatic rdc;
      host.xfer(`FCV_CMD_READ_CONFIG_ONE, 0, 24'h000000, 16'h0000, 0, rd);
   endtask
   // ==========================================================
   // Scenarios.
   task automatic t_reset;
      wp = 0;
      rdc;
      chk(rd, 8'h2E);
      chk(wp_n, 1);
      host.xfer(`FCV_CMD_READ_ANY_REG, 1, `FCV_ADDR_CFG_ONE_V, 0, 0, rd);
      chk(rd, 8'h2E);
      $display("done reset defaults");
   endtask
   task automatic t_write_any;
      int k;
      k = n_nv;
      wr(8'hFC);
      rdc;
      chk(rd, 8'h2C);
      chk(n_nv, k);
      chk(wp_n, 0);
      nv = 8'h02;
      rdc;
      chk(rd, 8'h00);
      four_bit_instruction_mode = 1;
      wr(8'h02);
      wr(8'h00);
      chk(wide, 1);
      four_bit_instruction_mode = 0;
      wr(8'h00);
      chk(wide, 0);
      $display("done write any");
   endtask
   task automatic t_wrr;
      int k, b, o;
      k = n_nv;
      b = n_bp;
      o = n_otp;
      write_status_config_cmd(16'h1C02);
      chk(n_nv, k + 1);
      chk(nvd[1], 1);
      chk(wide, 1);
      chk(oe_n, 1);
      ce = 0;
      wp = 1;
      io3 = 0;
      repeat (4) @(negedge clk);
      chk(io2d, 0);
      ce = 1;
      repeat (4) @(negedge clk);
      chk(io2d, 1);
      chk(wp_n, 1);
      chk(io3r, 0);
      chk(io3d, 0);
      io3 = 1;
      repeat (4) @(negedge clk);
      chk(io3r, 1);
      chk(n_bp, b + 1);
      chk(bpd, 8'h1C);
      otp;
      chk(n_otp, o + 1);
      $display("done write registers");
   endtask
   task automatic t_lock;
      int k, b, o;
      wr(8'h01);
      chk({lock, wide}, 8'h02);
      k = n_nv;
      b = n_bp;
      o = n_otp;
      write_status_config_cmd(16'h1C02);
      chk(n_bp, b);
      chk(err, 0);
      chk(n_nv, k + 1);
      chk(wide, 1);
      wr(8'h00);
      chk({lock, wide}, 8'h02);
      otp;
      chk(n_otp, o);
      chk(err, 1);
      sw = 1;
      @(negedge clk) sw = 0;
      repeat (4) @(negedge clk);
      chk({lock, err}, 8'h02);
      hw_n = 0;
      repeat (6) @(negedge clk);
      hw_n = 1;
      repeat (6) @(negedge clk);
      chk({lock, wide}, {6'h00, nv[0], nv[1]});
      nv = 8'h01;
      rst = 1;
      repeat (3) @(negedge clk);
      rst = 0;
      repeat (4) @(negedge clk);
      chk({lock, wide}, 8'h02);
      $display("done lock");
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      fail_count++;
      give_verdict;
   end
   initial begin
      repeat (8) @(negedge clk);
      rst = 0;
      repeat (4) @(negedge clk);
      t_reset;
      t_write_any;
      t_wrr;
      t_lock;
      give_verdict;
   end
endmodule // fcv_config_one_bench

// [fcv_config_one_props.sv]
// Assertions for the volatile configuration register one block.
// Assumes a bind to fcv_config_one; one clock domain.
`timescale 1ns/1ps
module fcv_config_one_props (
   input wire       i_clk,      // Block clock.
   input wire       i_sys_rst,  // Synchronous reset.
   input wire       i_ce,       // Clock enable.
   input wire       i_hw_rst_n, // Hardware reset pin.
   input wire       i_qpi,      // Four-bit instruction mode.
   input wire [7:0] i_nv_cfg,   // Nonvolatile register.
   input wire       o_wide,     // Width bit.
   input wire       o_lock,     // Lock bit.
   input wire       o_wp_n,     // Effective write-protect.
   input wire       o_nv_wr,    // Nonvolatile write pulse.
   input wire       o_bp_wr,    // Protect write pulse.
   input wire       o_otp_wr,   // OTP program pulse.
   input wire       o_prog_err  // Program error flag.
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // Counts edges with the reset pin high, so its synchroniser is settled.
   reg [2:0] hw_hi;
   always @(posedge i_clk) begin
      if (i_sys_rst || !i_hw_rst_n) hw_hi <= 3'h0;
      else if (hw_hi != 3'h7) hw_hi <= hw_hi + 3'h1;
   end
   wire hw_ok = i_hw_rst_n && (hw_hi >= 3'h3);
   chk_wp_wide:
      assert property (o_wide |-> o_wp_n) else $error("wp active in wide");
   chk_qpi_hold:
      assert property (hw_ok && o_wide && i_qpi |=> o_wide)
      else $error("width cleared in qpi");
   chk_lock_hold:
      assert property (hw_ok && o_lock |=> o_lock) else $error("lock lost");
   chk_nv_pulse:
      assert property (o_nv_wr |=> !o_nv_wr) else $error("nv pulse long");
   chk_bp_frozen:
      assert property (o_lock && $past(o_lock) |-> !o_bp_wr)
      else $error("protect write while locked");
   chk_otp_frozen:
      assert property (o_lock && $past(o_lock) |-> !o_otp_wr)
      else $error("otp write while locked");
   chk_err_cause:
      assert property ($rose(o_prog_err) |-> o_lock)
      else $error("error set while unlocked");
   chk_reset_load:
      assert property (!i_sys_rst && $past(i_sys_rst) && i_ce |=>
         {o_wide, o_lock} == $past(i_nv_cfg[1:0])) else $error("bad load");
   chk_hw_reload:
      assert property (!i_hw_rst_n [*4] |=> o_lock == $past(i_nv_cfg[0]))
      else $error("hw reset kept lock");
endmodule // fcv_config_one_props
bind fcv_config_one fcv_config_one_props u_props (.i_clk, .i_sys_rst, .i_ce,
   .i_hw_rst_n, .i_qpi, .i_nv_cfg, .o_wide, .o_lock, .o_wp_n, .o_nv_wr,
   .o_bp_wr, .o_otp_wr, .o_prog_err);

// [fcv_consts.vh]
// Constants for the volatile configuration register one block.
// Assumes inclusion by the fcv design files only.
`ifndef FCV_CONSTS_VH
`define FCV_CONSTS_VH
`define FCV_CMD_WRITE_STATUS_CONFIG 8'h01
`define FCV_CMD_READ_CONFIG_ONE     8'h35
`define FCV_CMD_READ_ANY_REG        8'h65
`define FCV_CMD_WRITE_ANY_REG       8'h71
`define FCV_CMD_OTP_PROGRAM         8'h42
`define FCV_ADDR_CFG_ONE_NV         24'h000002
`define FCV_ADDR_CFG_ONE_V          24'h800002
`define FCV_BIT_ORIGIN              5
`define FCV_BIT_VOLATILITY          3
`define FCV_BIT_PARAM_PLACE         2
`define FCV_BIT_WIDE                1
`define FCV_BIT_LOCK                0
`define FCV_BIT_QPI                 6
`define FCV_BIT_SRWD                7
`define FCV_RESET_VALUE             8'h00
`define FCV_ADDR_BYTES              3
`define FCV_OTP_TOP                 24'h0007FF
`endif

// [fcv_host.sv]
// Serial host model issuing register commands in clock mode 0.
// Assumes the block clock paces it; serial clock stands low between frames.
`timescale 1ns/1ps
module fcv_host (
   input  wire i_clk,  // Block clock.
   input  wire i_so,   // Serial data from the block.
   output reg  o_sck,  // Serial clock, 400 ns period.
   output reg  o_cs_n, // Chip select, active low.
   output reg  o_si    // Serial data to the block.
);
   initial begin
      o_sck = 0;
      o_cs_n = 1;
      o_si = 0;
   end
   // Data is taken just before the falling edge, when it has long settled.
   task automatic bit_io(input logic b, output logic r);
      o_si = b;
      repeat (4) @(negedge i_clk);
      o_sck = 1;
      repeat (4) @(negedge i_clk);
      r = i_so;
      o_sck = 0;
   endtask
   task automatic xfer(input logic [7:0] cmd, input logic adr,
      input logic [23:0] a, input logic [15:0] wd, input int nw,
      output logic [7:0] rd);
      logic r;
      @(negedge i_clk);
      o_cs_n = 0;
      for (int i = 7; i >= 0; i--) bit_io(cmd[i], r);
      if (adr) for (int i = 23; i >= 0; i--) bit_io(a[i], r);
      for (int i = nw * 8 - 1; i >= 0; i--) bit_io(wd[i], r);
      if (nw == 0) for (int i = 7; i >= 0; i--) bit_io(~o_si, rd[i]);
      repeat (4) @(negedge i_clk);
      o_cs_n = 1;
      o_si = ~o_si;
      repeat (8) @(negedge i_clk);
   endtask
endmodule // fcv_host

// [fcv_sync.v]
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes i_clk is the block clock; i_ce freezes it.
`timescale 1ns/1ps
module fcv_sync (
   input  wire i_clk,    // Block clock.
   input  wire i_sys_rst,// Synchronous reset, active high.
   input  wire i_ce,     // Clock enable.
   input  wire i_rst_val,// Value taken under reset.
   input  wire i_async,  // Asynchronous input.
   output reg  o_sync    // Synchronised output.
);
   reg stage1;

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         // Both stages start at the pin's idle level, so no false edge follows.
         stage1 <= i_rst_val;
         o_sync <= i_rst_val;
      end else if (i_ce) begin
         stage1 <= i_async;
         o_sync <= stage1;
      end
   end

endmodule // fcv_sync
